// file: verilog/tsp_pkg.sv
// Purpose: Shared constants and types for the 8-bit timer with shared prescaler.
// Assumes: AHB-Lite register access, 32-bit data, one aligned word per register.
// Notes:   Control bits, count, status and mask each occupy one word.
package tsp_pkg;

  // Register byte addresses.
  localparam logic [7:0] TSP_CTRL_ADDR   = 8'h00;
  localparam logic [7:0] TSP_COUNT_ADDR  = 8'h04;
  localparam logic [7:0] TSP_STATUS_ADDR = 8'h08;
  localparam logic [7:0] TSP_MASK_ADDR   = 8'h0C;

  // Control field positions.
  localparam int TSP_SRC_BIT    = 5;
  localparam int TSP_EDGE_BIT   = 4;
  localparam int TSP_ASSIGN_BIT = 3;
  localparam int TSP_RATE_LSB   = 0;
  localparam int TSP_RATE_W     = 3;
  localparam int TSP_FLAG_BIT   = 0;

  // Reset values.
  localparam logic [5:0] TSP_CTRL_RST  = 6'h3F;
  localparam logic [7:0] TSP_COUNT_RST = 8'h00;

  // Instruction cycle made of four phase clocks; sampling phases.
  localparam logic [1:0] TSP_PHASE_Q2   = 2'h1;
  localparam logic [1:0] TSP_PHASE_Q4   = 2'h3;
  localparam logic [1:0] TSP_INHIBIT_CY = 2'h2;
  localparam logic [7:0] TSP_COUNT_MAX  = 8'hFF;

  // AHB encodings.
  localparam logic [1:0] TSP_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] TSP_HRESP_OKAY    = 2'h0;

  typedef struct packed {
    logic                  count_source_select;
    logic                  count_edge_select;
    logic                  prescaler_assign;
    logic [TSP_RATE_W-1:0] prescale_rate;
  } tsp_ctrl_t;

  typedef struct packed {
    logic       pend;
    logic [7:0] addr;
  } tsp_wr_t;

  // Prescaler output tap: bit n divides the source by two to the n plus one.
  function automatic logic tsp_tap(input logic [7:0] presc, input logic [TSP_RATE_W-1:0] rate);
    tsp_tap = presc[rate];
  endfunction

endpackage

// file: verilog/tsp_timer.sv
// Purpose: 8-bit timer/counter with a shared 8-bit prescaler and overflow interrupt.
// Assumes: One clock hclk; four hclk cycles form one instruction cycle.
// Notes:   The watchdog counter itself lives outside; it sees wdt_tick and clear_watchdog too.
`timescale 1ns/1ps

// Operation
// - Source select clear: count one per instruction cycle without prescaler.
// - A count write stops counting for the next two instruction cycles.
// - Source select set: count edges of the external count pin.
// - Edge select clear counts rising edges, set counts falling edges.
// - Assign bit clear gives prescaler to timer, set gives it to watchdog.
// - The prescaler value cannot be read or written by software.
// - Timer prescale ratios run from 1:2 to 1:256 in powers of two.
// - Count rolling from FFh to 00h sets the overflow flag.
// - Interrupt is raised only while the overflow enable bit is set.
// - Timer stops in sleep, so no overflow and no wake.
// - Prescaler output sampled on phases two and four, increment one cycle later.
// - Prescaler is 8 bits; only its owner gets scaling.
// - With prescaler on timer, a count write clears the prescaler.
// - With prescaler on watchdog, clear-watchdog clears the prescaler.
module tsp_timer
  import tsp_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic      [1:0]  hresp,
  input  wire logic        ext_count_clock_pin,
  input  wire logic        sleep,
  input  wire logic        wdt_tick,
  input  wire logic        clear_watchdog_instruction,
  output logic             wdt_scaled_tick,
  output logic             irq
);

  tsp_ctrl_t   ctrl;
  tsp_ctrl_t   next_ctrl;
  tsp_wr_t     wr;
  tsp_wr_t     next_wr;
  logic [31:0] next_hrdata;
  logic [7:0]  count_register;
  logic [7:0]  next_count_register;
  logic [7:0]  presc;
  logic [7:0]  next_presc;
  logic        overflow_flag;
  logic        next_overflow_flag;
  logic        overflow_irq_enable;
  logic        next_overflow_irq_enable;
  logic [1:0]  inhibit;
  logic [1:0]  next_inhibit;
  logic [1:0]  phase;
  logic [1:0]  next_phase;
  logic        pin_s1;
  logic        pin_s2;
  logic        lvl_d;
  logic        samp;
  logic        next_samp;
  logic        inc_q;
  logic        next_inc_q;
  logic        next_wdt_scaled_tick;
  logic        next_irq;

  logic        addr_ok;
  logic        cnt_wr;
  logic        lvl;
  logic        src_event;
  logic        instr_tick;
  logic        presc_out;
  logic        timer_pulse;
  logic        inc;
  logic        inc_ok;
  logic        flag_set;
  logic        flag_clr;

  // Bus side: zero wait states, read data registered at the address phase.
  assign addr_ok = hsel && hready && (htrans == TSP_HTRANS_NONSEQ);
  assign cnt_wr  = wr.pend && (wr.addr == TSP_COUNT_ADDR);

  always_comb begin
    next_wr.pend = addr_ok && hwrite;
    next_wr.addr = haddr[7:0];
    next_hrdata  = hrdata;
    if (addr_ok && !hwrite) begin
      unique case (haddr[7:0])
        TSP_CTRL_ADDR:   next_hrdata = {26'h000_0000, ctrl};
        TSP_COUNT_ADDR:  next_hrdata = {24'h00_0000, count_register};
        TSP_STATUS_ADDR: next_hrdata = {31'h0000_0000, overflow_flag};
        TSP_MASK_ADDR:   next_hrdata = {31'h0000_0000, overflow_irq_enable};
        default:         next_hrdata = 32'h0000_0000; // The prescaler has no address.
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr        <= '0;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= TSP_HRESP_OKAY;
    end else begin
      wr        <= next_wr;
      hrdata    <= next_hrdata;
      hreadyout <= 1'b1;
      hresp     <= TSP_HRESP_OKAY;
    end
  end

  // Pin synchroniser; only the second stage is looked at.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
    end else begin
      pin_s1 <= ext_count_clock_pin;
      pin_s2 <= pin_s1;
    end
  end

  assign lvl        = pin_s2 ^ ctrl.count_edge_select;
  assign instr_tick = (phase == TSP_PHASE_Q4) && !sleep;
  assign src_event  = !sleep && (ctrl.count_source_select ? (lvl && !lvl_d) : instr_tick);

  always_comb begin
    next_phase               = phase + 2'h1;
    next_ctrl                = ctrl;
    next_count_register      = count_register;
    next_presc               = presc;
    next_inhibit             = inhibit;
    next_overflow_irq_enable = overflow_irq_enable;
    next_samp                = samp;
    next_inc_q               = 1'b0;
    timer_pulse              = 1'b0;
    presc_out                = lvl;
    next_wdt_scaled_tick     = wdt_tick;
    flag_set                 = 1'b0;
    flag_clr                 = 1'b0;
    // Prescaler belongs to one owner; the other runs unscaled.
    if (!ctrl.prescaler_assign) begin
      if (src_event) begin
        next_presc = presc + 8'h01;
      end
      presc_out = tsp_tap(presc, ctrl.prescale_rate);
      if (!ctrl.count_source_select) begin
        timer_pulse = src_event && !tsp_tap(presc, ctrl.prescale_rate) &&
                      tsp_tap(presc + 8'h01, ctrl.prescale_rate);
      end
    end else begin
      if (!ctrl.count_source_select) begin
        timer_pulse = src_event;
      end
      if (wdt_tick) begin
        next_presc = presc + 8'h01;
      end
      next_wdt_scaled_tick = wdt_tick && !tsp_tap(presc, ctrl.prescale_rate) &&
                             tsp_tap(presc + 8'h01, ctrl.prescale_rate);
    end
    // Counter mode: sample on phases two and four, increment one cycle later.
    if (!sleep && (phase == TSP_PHASE_Q2 || phase == TSP_PHASE_Q4)) begin
      next_samp  = presc_out;
      next_inc_q = ctrl.count_source_select && presc_out && !samp;
    end
    inc    = ctrl.count_source_select ? inc_q : timer_pulse;
    inc_ok = inc && (inhibit == 2'h0) && !sleep;
    if (inhibit != 2'h0 && instr_tick) begin
      next_inhibit = inhibit - 2'h1;
    end
    if (inc_ok) begin
      next_count_register = count_register + 8'h01;
      flag_set            = (count_register == TSP_COUNT_MAX);
    end
    if (ctrl.prescaler_assign && clear_watchdog_instruction) begin
      next_presc = 8'h00;
    end
    if (wr.pend) begin
      unique case (wr.addr)
        TSP_CTRL_ADDR: begin
          next_ctrl = tsp_ctrl_t'(hwdata[5:0]);
        end
        TSP_COUNT_ADDR: begin
          next_count_register = hwdata[7:0];
          next_inhibit        = TSP_INHIBIT_CY;
          if (!ctrl.prescaler_assign) begin
            next_presc = 8'h00;
          end
        end
        TSP_STATUS_ADDR: begin
          flag_clr = hwdata[TSP_FLAG_BIT];
        end
        TSP_MASK_ADDR: begin
          next_overflow_irq_enable = hwdata[TSP_FLAG_BIT];
        end
        default: begin
          next_ctrl = ctrl;
        end
      endcase
    end
    // A new overflow wins over a clear in the same cycle.
    next_overflow_flag = (overflow_flag && !flag_clr) || flag_set;
    next_irq           = next_overflow_flag && next_overflow_irq_enable;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase               <= 2'h0;
      ctrl                <= tsp_ctrl_t'(TSP_CTRL_RST);
      count_register      <= TSP_COUNT_RST;
      presc               <= 8'h00;
      inhibit             <= 2'h0;
      overflow_flag       <= 1'b0;
      overflow_irq_enable <= 1'b0;
      // Start from the level that the reset edge select gives an idle pin, so reset makes no false count.
      lvl_d               <= TSP_CTRL_RST[TSP_EDGE_BIT];
      samp                <= TSP_CTRL_RST[TSP_EDGE_BIT];
      inc_q               <= 1'b0;
      wdt_scaled_tick     <= 1'b0;
      irq                 <= 1'b0;
    end else begin
      phase               <= next_phase;
      ctrl                <= next_ctrl;
      count_register      <= next_count_register;
      presc               <= next_presc;
      inhibit             <= next_inhibit;
      overflow_flag       <= next_overflow_flag;
      overflow_irq_enable <= next_overflow_irq_enable;
      lvl_d               <= lvl;
      samp                <= next_samp;
      inc_q               <= next_inc_q;
      wdt_scaled_tick     <= next_wdt_scaled_tick;
      irq                 <= next_irq;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_count_write;
    cnt_wr;
  endsequence

  sequence s_inhibit_held;
    (inhibit != 2'h0) && !cnt_wr;
  endsequence

  AST_TIMER_INC: assert property (
    (!ctrl.count_source_select && ctrl.prescaler_assign && instr_tick && inhibit == 2'h0 && !cnt_wr)
      |=> count_register == $past(count_register) + 8'h01)
    else $error("timer mode did not count an instruction cycle");

  AST_WRITE_LOAD: assert property (
    s_count_write |=> (inhibit == TSP_INHIBIT_CY) && (count_register == $past(hwdata[7:0])))
    else $error("count write did not load value and inhibit");

  AST_INHIBIT_HOLD: assert property (
    s_inhibit_held |=> $stable(count_register))
    else $error("count changed during write inhibit");

  AST_COUNTER_INC: assert property (
    (ctrl.count_source_select && inc_q && inhibit == 2'h0 && !sleep && !cnt_wr)
      |=> count_register == $past(count_register) + 8'h01)
    else $error("counter mode missed a synchronised edge");

  AST_SAMPLE_DELAY: assert property (
    (ctrl.count_source_select && !sleep && phase == TSP_PHASE_Q2 && presc_out && !samp) |=> inc_q ##1 !inc_q)
    else $error("sampled edge did not give one increment pulse");

  AST_OVERFLOW: assert property (
    (inc_ok && count_register == TSP_COUNT_MAX && !cnt_wr) |=> overflow_flag && count_register == 8'h00)
    else $error("overflow did not set the flag");

  AST_FLAG_STICKY: assert property (
    (overflow_flag && !(wr.pend && wr.addr == TSP_STATUS_ADDR)) |=> overflow_flag)
    else $error("overflow flag cleared without software");

  AST_IRQ_MASK: assert property (
    irq == (overflow_flag && overflow_irq_enable))
    else $error("interrupt level does not follow flag and enable");

  AST_SLEEP_STOP: assert property (
    (sleep && !cnt_wr) |=> $stable(count_register) && !$rose(overflow_flag))
    else $error("timer advanced during sleep");

  AST_PRESC_CLR_WRITE: assert property (
    (cnt_wr && !ctrl.prescaler_assign) |=> presc == 8'h00)
    else $error("count write did not clear prescaler");

  AST_PRESC_CLR_WDT: assert property (
    (clear_watchdog_instruction && ctrl.prescaler_assign) |=> presc == 8'h00)
    else $error("clear-watchdog did not clear prescaler");

endmodule // tsp_timer

// file: dv/tsp_partner.sv
// Purpose: Far-side model: count pin source, watchdog time base and clear pulse.
// Assumes: Every output changes just after a rising edge of hclk.
// Notes:   The pin idles low and moves only when the bench asks.
`timescale 1ns/1ps
module tsp_partner (
  input  wire logic hclk,
  output logic      pin,
  output logic      tick,
  output logic      clr
);
  initial begin
    pin  = 1'b0;
    tick = 1'b0;
    clr  = 1'b0;
  end

  // Each level is held eight clocks, well above the two-phase sampling minimum.
  task automatic drive_pin(input logic lvl);
    repeat (8) @(posedge hclk);
    pin <= lvl;
  endtask

  task automatic wdt_ticks(input int n, input logic clear_after);
    repeat (n) begin
      repeat (3) @(posedge hclk);
      tick <= 1'b1;
      @(posedge hclk);
      tick <= 1'b0;
    end
    if (clear_after) begin
      @(posedge hclk);
      clr <= 1'b1;
      @(posedge hclk);
      clr <= 1'b0;
    end
  endtask
endmodule // tsp_partner

// file: dv/timer8_shared_prescaler_tb_top.sv
// Purpose: Self-checking bench for the timer with shared prescaler.
// Assumes: Zero-wait slave; four clocks form one instruction cycle.
// Notes:   Count ranges allow for the unknown phase of the instruction tick.
`timescale 1ns/1ps
module timer8_shared_prescaler_tb_top;
  import tsp_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, sleep, irq, wdt_scaled_tick;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [1:0]  htrans, hresp;
  logic [2:0]  hsize;
  logic        pin, tick, clr;
  int          errors, cmp_count, cyc, scaled_cnt;

  tsp_timer tsp_timer_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .ext_count_clock_pin(pin), .sleep(sleep), .wdt_tick(tick),
    .clear_watchdog_instruction(clr), .wdt_scaled_tick(wdt_scaled_tick), .irq(irq));
  tsp_partner tsp_partner_inst (.hclk(hclk), .pin(pin), .tick(tick), .clr(clr));

  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  always @(posedge hclk) begin
    cyc++;
    if (wdt_scaled_tick === 1'b1) scaled_cnt++;
    if (cyc == 30000) begin
      errors++;
      complete_run();
    end
  end

  task automatic complete_run;
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input logic [31:0] got, input int lo, input int hi);
    cmp_count++;
    if ($isunknown(got) || got < lo || got > hi) begin
      errors++;
      $display("MISMATCH t=%0t got %h range %0d..%0d", $time, got, lo, hi);
    end
  endtask

  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    htrans <= TSP_HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    xfer(a, 1'b1, v, d);
  endtask

  task automatic rd(input logic [7:0] a);
    xfer(a, 1'b0, 32'h0000_0000, d);
  endtask

  task automatic t_reset;
    logic [7:0]  a[5] = '{TSP_CTRL_ADDR, TSP_COUNT_ADDR, TSP_STATUS_ADDR, TSP_MASK_ADDR, 8'h10};
    logic [31:0] e[5] = '{32'h0000_003F, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
    for (int i = 0; i < 5; i++) begin
      rd(a[i]);
      chk(d, e[i]);
    end
    chk({30'h0, hresp}, 32'h0000_0000);
    chk({31'h0, hreadyout}, 32'h0000_0001);
  endtask

  task automatic t_timer;
    wr(TSP_CTRL_ADDR, 32'h0000_0008);
    wr(TSP_COUNT_ADDR, 32'h0000_0000);
    repeat (80) @(posedge hclk);
    rd(TSP_COUNT_ADDR);
    chk_rng(d, 17, 19);
  endtask

  task automatic t_presc;
    tsp_partner_inst.wdt_ticks(0, 1'b1);
    for (int r = 0; r < 8; r++) begin
      wr(TSP_CTRL_ADDR, r);
      wr(TSP_COUNT_ADDR, 32'h0000_0000);
      repeat (24 << r) @(posedge hclk);
      rd(TSP_COUNT_ADDR);
      chk_rng(d, 2, 3);
    end
  endtask

  task automatic t_counter;
    tsp_partner_inst.wdt_ticks(0, 1'b1);
    wr(TSP_COUNT_ADDR, 32'h0000_0000);
    for (int e = 0; e < 2; e++) begin
      wr(TSP_CTRL_ADDR, 32'h0000_0028 | (e << TSP_EDGE_BIT));
      repeat (16) @(posedge hclk);
      wr(TSP_COUNT_ADDR, 32'h0000_0000);
      repeat (16) @(posedge hclk);
      for (int k = 0; k < 5; k++) tsp_partner_inst.drive_pin(k % 2 == 0);
      repeat (24) @(posedge hclk);
      rd(TSP_COUNT_ADDR);
      chk(d, e ? 32'h0000_0002 : 32'h0000_0003);
      tsp_partner_inst.drive_pin(1'b0);
    end
  endtask

  task automatic t_irq;
    wr(TSP_CTRL_ADDR, 32'h0000_0008);
    wr(TSP_COUNT_ADDR, 32'h0000_00FE);
    repeat (40) @(posedge hclk);
    rd(TSP_STATUS_ADDR);
    chk(d, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0000_0000);
    wr(TSP_MASK_ADDR, 32'h0000_0001);
    repeat (2) @(posedge hclk);
    chk({31'h0, irq}, 32'h0000_0001);
    repeat (40) @(posedge hclk);
    rd(TSP_STATUS_ADDR);
    chk(d, 32'h0000_0001);
    wr(TSP_STATUS_ADDR, 32'h0000_0001);
    repeat (2) @(posedge hclk);
    chk({31'h0, irq}, 32'h0000_0000);
  endtask

  task automatic t_sleep;
    wr(TSP_COUNT_ADDR, 32'h0000_00FC);
    sleep <= 1'b1;
    repeat (200) @(posedge hclk);
    rd(TSP_COUNT_ADDR);
    chk(d, 32'h0000_00FC);
    chk({31'h0, irq}, 32'h0000_0000);
    sleep <= 1'b0;
    repeat (40) @(posedge hclk);
    chk({31'h0, irq}, 32'h0000_0001);
    wr(TSP_STATUS_ADDR, 32'h0000_0001);
  endtask

  task automatic t_wdt;
    wr(TSP_CTRL_ADDR, 32'h0000_0008);
    scaled_cnt = 0;
    tsp_partner_inst.wdt_ticks(16, 1'b0);
    repeat (4) @(posedge hclk);
    chk(scaled_cnt, 32'h0000_0008);
    tsp_partner_inst.wdt_ticks(0, 1'b1);
    wr(TSP_CTRL_ADDR, 32'h0000_0000);
    scaled_cnt = 0;
    tsp_partner_inst.wdt_ticks(16, 1'b0);
    repeat (4) @(posedge hclk);
    chk(scaled_cnt, 32'h0000_0010);
    tsp_partner_inst.wdt_ticks(0, 1'b1);
    wr(TSP_COUNT_ADDR, 32'h0000_0000);
    wr(TSP_CTRL_ADDR, 32'h0000_0009);
    tsp_partner_inst.wdt_ticks(0, 1'b1);
    scaled_cnt = 0;
    // A clear after every single tick keeps the divide-by-four prescaler from ever firing.
    repeat (3) tsp_partner_inst.wdt_ticks(1, 1'b1);
    repeat (4) @(posedge hclk);
    chk(scaled_cnt, 32'h0000_0000);
    tsp_partner_inst.wdt_ticks(4, 1'b0);
    repeat (4) @(posedge hclk);
    chk(scaled_cnt, 32'h0000_0001);
  endtask

  initial begin
    {hsel, hwrite, sleep} = 3'h0;
    haddr   = 32'h0000_0000;
    hwdata  = 32'h0000_0000;
    htrans  = 2'h0;
    hsize   = 3'h2;
    hresetn = 1'b0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_timer();
    t_presc();
    t_counter();
    t_irq();
    t_sleep();
    t_wdt();
    complete_run();
  end
endmodule // timer8_shared_prescaler_tb_top
